/* design/hscc_clock_control.sv */
// High-speed clock select control: pin modes, oscillator start and stop,
// stabilization counting, main, peripheral and processor clock selection.
// Assumes a Wishbone master on clk and asynchronous supply-good and wake pins.
//
// Rules for this block, its software and its option settings
// R1 - Hold internal reset until supply good; internal oscillator then runs.
// R2 - After reset the processor runs from the internal high-speed clock.
// R3 - After reset both high-speed clock pins act as port pins.
// R4 - Software sets gain 0 up to 10 MHz, 1 above.
// R5 - Gain field accepts only one change after each reset release.
// R6 - Writing gain to 1 gates processor clock at least five microseconds.
// R7 - External select 0 with pin select 1 gives crystal oscillation mode.
// R8 - Both selects 1: first pin stays port, second takes external clock.
// R9 - Clearing stop bit starts oscillator or enables external clock input.
// R10 - Setting stop bit stops oscillation or disables external clock input.
// R11 - Software reads stabilization status and waits before using crystal.
// R12 - Software keeps pin and external selects fixed while clock runs.
// R13 - External clock input needs no stabilization wait.
// R14 - Both main selects 1 put high-speed clock on main and peripheral.
// R15 - With high-speed main clock no other peripheral source is possible.
// R16 - Processor source select 0 feeds divided main clock to processor.
// R17 - Divider codes 0 to 4 give 1 to 16, default 2, others prohibited.
// R18 - STOP enters STOP mode and halts the high-speed clock.
// R19 - Software sets stabilization select before STOP or checks the counter.
// R20 - Software switches to crystal only after oscillation has stabilized.
// R21 - The reset threshold option must be set to 1.
// R22 - Both selects 0 put internal clock on main and peripheral.
// R23 - Software moves processor off high-speed clock before stopping it.
// R24 - Stabilization counter restarts from zero at every oscillator start.

`timescale 1ns/1ps

module hscc_clock_control
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        powerGood,
  input  wire logic                        wakeRequest,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [hscc_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [hscc_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [hscc_pkg::DATA_W-1:0] wb_dat_o,
  output logic                             wb_ack_o,
  output logic                             internalReset,
  output logic                             portPinAIsPort,
  output logic                             portPinBIsPort,
  output logic                             crystalOscEnable,
  output logic                             externalClockEnable,
  output logic                             oscGain,
  output logic                             mainUsesHighSpeed,
  output logic                             periphUsesHighSpeed,
  output logic                             cpuClockEnable,
  output logic                             stopMode
);
  import hscc_pkg::*;

  // ***************************************************************
  // Power-on hold and pin synchronisers
  // ***************************************************************
  logic             pgMeta;
  logic             pgSync;
  logic             wakeMeta;
  logic             wakeSync;
  logic             coreRst;

  always_ff @(posedge clk)
  begin
    pgMeta   <= powerGood;
    pgSync   <= pgMeta;
    wakeMeta <= wakeRequest;
    wakeSync <= wakeMeta;
  end

  // The whole block, bus included, stays in reset until the supply is good.
  always_ff @(posedge clk)
  begin
    coreRst       <= rst || !pgSync;  // R1
    internalReset <= rst || !pgSync;  // R1
  end

  // ***************************************************************
  // Control state
  // ***************************************************************
  logic             gain;
  logic             gainLocked;
  logic [HOLD_W-1:0] gainHold;
  logic             pinModeSel;
  logic             extClkSel;
  logic             hsStop;
  logic             modeBit;
  logic             mainSrcSel;
  logic [2:0]       divCode;
  logic             procSrcSel;
  logic [2:0]       stabSel;
  logic             stopState;
  logic [CNT_W-1:0] stabCount;
  logic             hsRunning;
  logic             hsStable;
  logic             mainHs;
  logic             busWrite;
  logic             busRead;

  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                    && wb_sel_i[0];
  assign busRead  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  function automatic logic [CNT_W-1:0] stab_target(input logic [2:0] sel);
    stab_target = CNT_W'(1) << (STAB_BASE_SHIFT + int'(sel));
  endfunction

  function automatic logic div_code_ok(input logic [2:0] code);
    div_code_ok = code <= DIV_MAX_CODE;
  endfunction

  // ***************************************************************
  // Oscillator gain, one change per reset
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (coreRst)
    begin
      gain       <= 1'b0;
      gainLocked <= 1'b0;
    end
    else if (busWrite && wb_adr_i == OFF_OSC_CTRL && !gainLocked
             && wb_dat_i[BIT_GAIN] != gain)
    begin
      gain       <= wb_dat_i[BIT_GAIN];  // R5
      gainLocked <= 1'b1;  // R5
    end
  end

  // A rising gain retunes the amplifier, so the processor clock pauses.
  always_ff @(posedge clk)
  begin
    if (coreRst)
      gainHold <= '0;
    else if (busWrite && wb_adr_i == OFF_OSC_CTRL && !gainLocked
             && wb_dat_i[BIT_GAIN] && !gain)
      gainHold <= HOLD_W'(GAIN_HOLD_CYC);  // R6
    else if (gainHold != '0)
      gainHold <= gainHold - HOLD_W'(1);
  end

  // ***************************************************************
  // Register writes
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (coreRst)
    begin
      pinModeSel <= 1'b0;  // R3
      extClkSel  <= 1'b0;
      hsStop     <= 1'b1;
      modeBit    <= 1'b0;  // R2
      mainSrcSel <= 1'b0;  // R2
      divCode    <= DIV_RESET;  // R17
      procSrcSel <= 1'b0;
      stabSel    <= STAB_SEL_RESET;
    end
    else if (busWrite)
    begin
      if (wb_adr_i == OFF_OSC_CTRL)
      begin
        pinModeSel <= wb_dat_i[BIT_PIN_MODE];
        extClkSel  <= wb_dat_i[BIT_EXT_CLK];
      end
      else if (wb_adr_i == OFF_MAIN_OSC)
        hsStop <= wb_dat_i[BIT_HS_STOP];  // R9 R10
      else if (wb_adr_i == OFF_MAIN_MODE)
      begin
        modeBit    <= wb_dat_i[BIT_MODE];
        mainSrcSel <= wb_dat_i[BIT_MAIN_SRC];
      end
      else if (wb_adr_i == OFF_PROC_CLK)
      begin
        procSrcSel <= wb_dat_i[BIT_PROC_SRC];
        // A prohibited divider code is dropped and the old ratio stays.
        if (div_code_ok(wb_dat_i[DIV_LSB +: 3]))
          divCode <= wb_dat_i[DIV_LSB +: 3];  // R17
      end
      else if (wb_adr_i == OFF_STAB_SELECT)
        stabSel <= wb_dat_i[2:0];
    end
  end

  // ***************************************************************
  // STOP mode
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (coreRst)
      stopState <= 1'b0;
    else if (busWrite && wb_adr_i == OFF_STOP_CTRL && wb_dat_i[BIT_STOP])
      stopState <= 1'b1;  // R18
    else if (wakeSync)
      stopState <= 1'b0;
  end

  // ***************************************************************
  // Oscillator run state and stabilization counter
  // ***************************************************************
  always_comb
  begin
    hsRunning = !hsStop && !stopState && pinModeSel;  // R9 R10 R18
    mainHs    = mainSrcSel && modeBit;  // R14 R22
  end

  // The counter is cleared whenever the oscillator is off, so every start
  // counts from zero; it saturates rather than wrapping back to unstable.
  always_ff @(posedge clk)
  begin
    if (coreRst || !hsRunning)
      stabCount <= '0;  // R24
    else if (stabCount != '1)
      stabCount <= stabCount + CNT_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (coreRst || !hsRunning)
      hsStable <= 1'b0;
    else
      hsStable <= extClkSel || stabCount >= stab_target(stabSel);  // R13
  end

  // ***************************************************************
  // Pins and clock routing
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (coreRst)
    begin
      portPinAIsPort      <= 1'b1;  // R3
      portPinBIsPort      <= 1'b1;  // R3
      crystalOscEnable    <= 1'b0;
      externalClockEnable <= 1'b0;
      oscGain             <= 1'b0;
      mainUsesHighSpeed   <= 1'b0;  // R2
      periphUsesHighSpeed <= 1'b0;
      stopMode            <= 1'b0;
    end
    else
    begin
      portPinAIsPort      <= !pinModeSel || extClkSel;  // R7 R8
      portPinBIsPort      <= !pinModeSel;  // R7 R8
      crystalOscEnable    <= hsRunning && !extClkSel;  // R9 R10
      externalClockEnable <= hsRunning && extClkSel;  // R9 R10
      oscGain             <= gain;
      mainUsesHighSpeed   <= mainHs;  // R14 R22
      periphUsesHighSpeed <= mainHs;  // R15
      stopMode            <= stopState;  // R18
    end
  end

  // ***************************************************************
  // Processor clock divider
  // ***************************************************************
  logic [3:0] divCount;
  logic       cpuRun;
  logic       divTick;

  // The processor also waits while its high-speed source is not yet stable.
  assign cpuRun  = !stopState && gainHold == '0 && !(mainHs && !hsStable);
  assign divTick = (divCount & ((4'h1 << divCode) - 4'h1)) == 4'h0;

  always_ff @(posedge clk)
  begin
    if (coreRst)
      divCount <= 4'h0;
    else
      divCount <= divCount + 4'h1;  // R17
  end

  always_ff @(posedge clk)
  begin
    if (coreRst)
      cpuClockEnable <= 1'b0;
    else
      cpuClockEnable <= cpuRun && !procSrcSel && divTick;  // R6 R16 R17
  end

  // ***************************************************************
  // Wishbone answer
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (coreRst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= '0;
      if (busRead)
      begin
        if (wb_adr_i == OFF_OSC_CTRL)
          wb_dat_o <= DATA_W'({extClkSel, pinModeSel, gain});
        else if (wb_adr_i == OFF_MAIN_OSC)
          wb_dat_o <= DATA_W'(hsStop);
        else if (wb_adr_i == OFF_MAIN_MODE)
          wb_dat_o <= DATA_W'({mainHs, mainSrcSel, modeBit});
        else if (wb_adr_i == OFF_PROC_CLK)
          wb_dat_o <= DATA_W'({procSrcSel, procSrcSel, 1'b0, divCode});
        else if (wb_adr_i == OFF_STAB_STATUS)
          wb_dat_o <= DATA_W'({hsStable, 15'h0000, stabCount});
        else if (wb_adr_i == OFF_STAB_SELECT)
          wb_dat_o <= DATA_W'(stabSel);
        else if (wb_adr_i == OFF_STOP_CTRL)
          wb_dat_o <= DATA_W'(stopState);
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  sequence s_gain_rise;
    !gain ##1 gain;
  endsequence
  sequence s_held_8;
    (gainHold != '0 && !cpuClockEnable) [*8];
  endsequence

  a_gain_once: assert property (@(posedge clk) disable iff (coreRst)  // R5
    gainLocked |=> $stable(gain))
    else $error("Gain changed twice after reset.");
  a_gain_gate: assert property (@(posedge clk) disable iff (coreRst)  // R6
    s_gain_rise |-> ##1 s_held_8)
    else $error("Processor clock not gated after gain rise.");
  a_gated_clock: assert property (@(posedge clk) disable iff (coreRst)  // R6
    $past(gainHold) != '0 |-> !cpuClockEnable)
    else $error("Processor clock ran during gain hold.");
  a_pin_crystal: assert property (@(posedge clk) disable iff (coreRst)  // R7
    (pinModeSel && !extClkSel) |=> !portPinAIsPort && !portPinBIsPort)
    else $error("Crystal mode did not take both pins.");
  a_pin_external: assert property (@(posedge clk) disable iff (coreRst)  // R8
    (pinModeSel && extClkSel) |=> portPinAIsPort && !portPinBIsPort)
    else $error("External mode pin usage wrong.");
  a_stop_osc: assert property (@(posedge clk) disable iff (coreRst)  // R10
    hsStop |=> !crystalOscEnable && !externalClockEnable)
    else $error("Oscillator ran with stop bit set.");
  a_stop_halts: assert property (@(posedge clk) disable iff (coreRst)  // R18
    stopState |=> !crystalOscEnable && !externalClockEnable
                  && !cpuClockEnable)
    else $error("Clock ran in STOP mode.");
  a_count_restart: assert property (@(posedge clk) disable iff (coreRst) // R24
    $rose(hsRunning) |-> stabCount == '0 ##1 stabCount == CNT_W'(1))
    else $error("Stabilization count did not restart.");
  a_ext_no_wait: assert property (@(posedge clk) disable iff (coreRst)  // R13
    (hsRunning && extClkSel) [*2] |-> hsStable)
    else $error("External clock waited for stabilization.");
  a_periph_main: assert property (@(posedge clk) disable iff (coreRst)  // R15
    periphUsesHighSpeed == mainUsesHighSpeed)
    else $error("Peripheral clock differs from main clock.");
  a_div_default: assert property (@(posedge clk)  // R17
    $fell(coreRst) |-> divCode == DIV_RESET)
    else $error("Divider not at divide by two after reset.");
  a_ack_single: assert property (@(posedge clk) disable iff (coreRst)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held for two cycles.");

endmodule

/* design/hscc_pkg.sv */
// Constants of the high-speed clock select control block.
// Assumes a 250 MHz core clock and a 32-bit classic Wishbone slave port.
package hscc_pkg;

  // ***************************************************************
  // Bus and register map
  // ***************************************************************
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  OFF_OSC_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_MAIN_OSC    = 8'h04;
  localparam logic [7:0]  OFF_MAIN_MODE   = 8'h08;
  localparam logic [7:0]  OFF_PROC_CLK    = 8'h0c;
  localparam logic [7:0]  OFF_STAB_STATUS = 8'h10;
  localparam logic [7:0]  OFF_STAB_SELECT = 8'h14;
  localparam logic [7:0]  OFF_STOP_CTRL   = 8'h18;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int BIT_GAIN       = 0;
  localparam int BIT_PIN_MODE   = 1;
  localparam int BIT_EXT_CLK    = 2;
  localparam int BIT_HS_STOP    = 0;
  localparam int BIT_MODE       = 0;
  localparam int BIT_MAIN_SRC   = 1;
  localparam int BIT_MAIN_STAT  = 2;
  localparam int DIV_LSB        = 0;
  localparam int BIT_PROC_SRC   = 4;
  localparam int BIT_PROC_STAT  = 5;
  localparam int BIT_STOP       = 0;

  // ***************************************************************
  // Reset values and timing
  // ***************************************************************
  localparam logic [2:0]  DIV_RESET       = 3'h1;
  localparam logic [2:0]  DIV_MAX_CODE    = 3'h4;
  localparam logic [2:0]  STAB_SEL_RESET  = 3'h7;
  localparam int          STAB_BASE_SHIFT = 8;
  localparam int          CLK_MHZ         = 250;
  localparam int          GAIN_HOLD_US    = 5;
  localparam int          GAIN_HOLD_CYC   = GAIN_HOLD_US * CLK_MHZ;
  localparam int          CNT_W           = 16;
  localparam int          HOLD_W          = 11;

endpackage

/* testbench/hscc_clock_source.sv */
// Model of the crystal resonator or external clock source.
// Assumes the enables of the control block on clk.
`timescale 1ns/1ps

module hscc_clock_source
(
  input  wire logic        clk,
  input  wire logic        crystalOscEnable,
  input  wire logic        externalClockEnable,
  output logic             sourceClock,
  output logic [15:0]      edgeCount
);
  // The source stands still at 0 when disabled, so a dead clock is seen.
  // One process owns both outputs, so each has a single driver.
  initial
  begin
    sourceClock = 1'b0;
    edgeCount = 16'h0000;
    forever
    begin
      @(posedge clk);
      if (crystalOscEnable || externalClockEnable)
      begin
        sourceClock <= !sourceClock;
        edgeCount <= edgeCount + 16'h0001;
      end
      else
      begin
        sourceClock <= 1'b0;
      end
    end
  end
endmodule

/* testbench/test_high_speed_clock_select_control.sv */
// Self-checking bench of the clock select control block.
// Assumes the package constants and a one-cycle Wishbone answer.
`timescale 1ns/1ps

module test_high_speed_clock_select_control;
  import hscc_pkg::*;
  typedef struct packed
  {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
  } hscc_row_t;
  // ************************************************
  // Signals
  // ************************************************
  logic              clk;
  logic              rst;
  logic              powerGood;
  logic              wakeRequest;
  logic              cyc;
  logic              stb;
  logic              we;
  logic [ADDR_W-1:0] adr;
  logic [3:0]        sel;
  logic [3:0]        wsel;
  logic [DATA_W-1:0] dat;
  logic [DATA_W-1:0] dout;
  logic              ack;
  logic              internalReset;
  logic              pinA;
  logic              pinB;
  logic              xtalOn;
  logic              extOn;
  logic              gain;
  logic              mainHs;
  logic              perHs;
  logic              cpuTick;
  logic              stopMode;
  logic              srcClk;
  logic [15:0]       edges;
  logic [15:0]       e0;
  logic [31:0]       q;
  int                bad_count;
  int                n_tests;
  int                k;
  int                n;
  // Divider code 5 is prohibited, so the old code 4 must remain.
  // The last row moves the processor off the main clock, status bit too.
  hscc_row_t rows [8] = '{
    '{8'h0c, 32'h0, 32'h0}, '{8'h0c, 32'h4, 32'h4},
    '{8'h0c, 32'h5, 32'h4}, '{8'h0c, 32'h1, 32'h1},
    '{8'h14, 32'h3, 32'h3}, '{8'h08, 32'h0, 32'h0},
    '{8'h20, 32'hff, 32'h0}, '{8'h0c, 32'h11, 32'h31}};

  hscc_clock_control hscc_clock_control_i
  (
    .clk(clk), .rst(rst), .powerGood(powerGood),
    .wakeRequest(wakeRequest), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dout), .wb_ack_o(ack), .internalReset(internalReset),
    .portPinAIsPort(pinA), .portPinBIsPort(pinB),
    .crystalOscEnable(xtalOn), .externalClockEnable(extOn),
    .oscGain(gain), .mainUsesHighSpeed(mainHs),
    .periphUsesHighSpeed(perHs), .cpuClockEnable(cpuTick),
    .stopMode(stopMode)
  );

  hscc_clock_source hscc_clock_source_i
  (
    .clk(clk), .crystalOscEnable(xtalOn),
    .externalClockEnable(extOn), .sourceClock(srcClk),
    .edgeCount(edges)
  );
  // ************************************************
  // Tasks
  // ************************************************
  task automatic chk(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic chkw(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: word %h not %h", $time, g, e);
    end
  endtask

  // A short pause after release lets derived outputs settle.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= wsel;
    dat <= d;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (ack !== 1'b1 && t < 50);
    if (ack !== 1'b1)
    begin
      bad_count++;
      $display("unexpected at %0t: no acknowledge", $time);
    end
    r = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Waits for a tick (k cycles), then measures the next gap (n).
  task automatic gap(output int kk, output int nn);
    kk = 0;
    nn = 0;
    @(posedge clk);
    while (cpuTick !== 1'b1 && kk < 3000)
    begin
      @(posedge clk);
      kk++;
    end
    do
    begin
      @(posedge clk);
      nn++;
    end
    while (cpuTick !== 1'b1 && nn < 3000);
    if (cpuTick !== 1'b1)
    begin
      bad_count++;
      $display("unexpected at %0t: no processor tick", $time);
    end
  endtask

  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ************************************************
  // Stimulus
  // ************************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report;
  end

  initial
  begin
    rst = 1'b1;
    powerGood = 1'b0;
    wakeRequest = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'hf;
    wsel = 4'hf;
    dat = '0;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk(internalReset, 1'b1, "reset without supply");
    powerGood <= 1'b1;
    repeat (8) @(posedge clk);
    chk(internalReset, 1'b0, "reset kept");
    chk(pinA, 1'b1, "pin a not port");
    chk(pinB, 1'b1, "pin b not port");
    chk(mainHs, 1'b0, "main not internal");
    gap(k, n);
    chkw(32'(n), 32'h2);
    wb(1'b0, OFF_MAIN_OSC, 32'h0, q);
    chkw(q, 32'h1);
    wb(1'b0, OFF_STAB_SELECT, 32'h0, q);
    chkw(q, 32'h7);
    $display("test reset done");
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].a, rows[i].d, q);
      wb(1'b0, rows[i].a, 32'h0, q);
      chkw(q, rows[i].q);
    end
    n = 0;
    repeat (32)
    begin
      @(posedge clk);
      if (cpuTick !== 1'b0)
        n++;
    end
    chkw(32'(n), 32'h0);
    wb(1'b1, OFF_PROC_CLK, 32'h1, q);
    wsel = 4'he;
    wb(1'b1, OFF_STAB_SELECT, 32'h5, q);
    wsel = 4'hf;
    wb(1'b0, OFF_STAB_SELECT, 32'h0, q);
    chkw(q, 32'h3);
    $display("test table done");
    wb(1'b1, OFF_OSC_CTRL, 32'h1, q);
    chk(gain, 1'b1, "gain not set");
    gap(k, n);
    chk(k >= 1230 && k <= 1260, 1'b1, "gain hold length");
    wb(1'b1, OFF_OSC_CTRL, 32'h0, q);
    chk(gain, 1'b1, "second gain change taken");
    $display("test gain done");
    wb(1'b1, OFF_OSC_CTRL, 32'h3, q);
    chk(pinA, 1'b0, "pin a in crystal mode");
    chk(pinB, 1'b0, "pin b in crystal mode");
    chk(xtalOn, 1'b0, "runs while stopped");
    wb(1'b1, OFF_MAIN_OSC, 32'h0, q);
    chk(xtalOn, 1'b1, "crystal not started");
    e0 = edges;
    wb(1'b0, OFF_STAB_STATUS, 32'h0, q);
    chk(q[31], 1'b0, "stable too early");
    chk(edges != e0, 1'b1, "source idle");
    repeat (2100) @(posedge clk);
    wb(1'b0, OFF_STAB_STATUS, 32'h0, q);
    chk(q[31], 1'b1, "not stable after 2048");
    wb(1'b1, OFF_MAIN_OSC, 32'h1, q);
    chk(xtalOn, 1'b0, "crystal not stopped");
    e0 = edges;
    repeat (4) @(posedge clk);
    chk(edges == e0, 1'b1, "source still runs");
    wb(1'b1, OFF_MAIN_OSC, 32'h0, q);
    wb(1'b0, OFF_STAB_STATUS, 32'h0, q);
    chk(q[15:0] < 16'h0010, 1'b1, "counter not restarted");
    chk(q[31], 1'b0, "stable kept over restart");
    repeat (2100) @(posedge clk);
    wb(1'b1, OFF_MAIN_MODE, 32'h3, q);
    chk(mainHs, 1'b1, "main not high-speed");
    chk(perHs, 1'b1, "peripheral not high-speed");
    wb(1'b0, OFF_MAIN_MODE, 32'h0, q);
    chk(q[2], 1'b1, "main status");
    gap(k, n);
    chkw(32'(n), 32'h2);
    wb(1'b1, OFF_MAIN_MODE, 32'h0, q);
    chk(mainHs, 1'b0, "main not internal");
    chk(perHs, 1'b0, "peripheral not internal");
    $display("test crystal done");
    wb(1'b1, OFF_MAIN_OSC, 32'h1, q);
    wb(1'b1, OFF_OSC_CTRL, 32'h7, q);
    chk(pinA, 1'b1, "pin a left port");
    chk(pinB, 1'b0, "pin b not clock input");
    wb(1'b1, OFF_MAIN_OSC, 32'h0, q);
    chk(extOn, 1'b1, "external not enabled");
    chk(xtalOn, 1'b0, "crystal in external mode");
    wb(1'b0, OFF_STAB_STATUS, 32'h0, q);
    chk(q[31], 1'b1, "external needs wait");
    wb(1'b1, OFF_STOP_CTRL, 32'h1, q);
    chk(stopMode, 1'b1, "stop not entered");
    chk(extOn, 1'b0, "clock runs in stop");
    wakeRequest <= 1'b1;
    repeat (6) @(posedge clk);
    chk(stopMode, 1'b0, "stop not released");
    wakeRequest <= 1'b0;
    $display("test external done");
    for (int d = 0; d < 5; d++)
    begin
      wb(1'b1, OFF_PROC_CLK, 32'(d), q);
      gap(k, n);
      chkw(32'(n), 32'h1 << d);
    end
    $display("test divider done");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk(internalReset, 1'b1, "mid-run reset missed");
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(pinA, 1'b1, "pin a not port again");
    chk(extOn, 1'b0, "external kept over reset");
    chk(gain, 1'b0, "gain kept over reset");
    wb(1'b0, OFF_PROC_CLK, 32'h0, q);
    chkw(q, 32'(DIV_RESET));
    wb(1'b1, OFF_OSC_CTRL, 32'h1, q);
    chk(gain, 1'b1, "gain locked after reset");
    $display("test second reset done");
    final_report;
  end
endmodule
